// ===== rtl/afc_consts.vh
// Register offsets, field positions, reset values and codes for fan control
`ifndef AFC_CONSTS_VH
`define AFC_CONSTS_VH
`define AFC_OFF_MAN1     8'h30
`define AFC_OFF_MAN2     8'h31
`define AFC_OFF_MAN3     8'h32
`define AFC_OFF_CEIL1    8'h38
`define AFC_OFF_CEIL2    8'h39
`define AFC_OFF_CEIL3    8'h3A
`define AFC_OFF_CFG1     8'h5C
`define AFC_OFF_CFG2     8'h5D
`define AFC_OFF_CFG3     8'h5E
`define AFC_OFF_ACOU     8'h62
`define AFC_OFF_FLOOR1   8'h64
`define AFC_OFF_FLOOR2   8'h65
`define AFC_OFF_FLOOR3   8'h66
`define AFC_OFF_TSTA     8'h67
`define AFC_OFF_TSTL     8'h68
`define AFC_OFF_TSTB     8'h69
`define AFC_OFF_HYST     8'h6A
`define AFC_OFF_STATUS   8'h6B
`define AFC_BHV_HI       7
`define AFC_BHV_LO       5
`define AFC_FMT_BIT      0
`define AFC_KEEP1_BIT    5
`define AFC_BHV_REM_A    3'h0
`define AFC_BHV_LOCAL    3'h1
`define AFC_BHV_REM_B    3'h2
`define AFC_BHV_FULL     3'h3
`define AFC_BHV_OFF      3'h4
`define AFC_BHV_LB_MAX   3'h5
`define AFC_BHV_ALL_MAX  3'h6
`define AFC_BHV_MANUAL   3'h7
`define AFC_RST_CFG      8'h80
`define AFC_RST_CEIL     8'hFF
`define AFC_RST_FLOOR    8'h80
`define AFC_RST_TSTART   8'h9A
`define AFC_RST_HYST     8'h04
`define AFC_RST_MAN      8'h00
`define AFC_RST_ACOU     8'h00
`define AFC_DUTY_FULL    8'hFF
`define AFC_TACHOMETER_INPUT_EDGES   2'h2
`endif

// ===== rtl/afc_fan_mux.v
// Fan drive selection, start and stop thresholds and duty limits
// Contract
// - Behaviour 011 drives the output at full duty regardless of temperature.
// - Behaviour 100 holds the output off; that code is the reset value.
// - Behaviour 111 is manual: the writable duty register sets output duty.
// - Behaviour 101 drives the larger duty of local and remote B.
// - Behaviour 000 derives automatic duty from remote A alone.
// - Behaviour 001 derives automatic duty from local alone.
// - Behaviour 010 derives automatic duty from remote B alone.
// - Behaviour 110 drives the largest duty of all three channels.
// - Each channel has an 8-bit start threshold, twos-complement or offset-64.
// - Above the start threshold the fan turns on at its floor duty.
// - Fan turns off below threshold minus hysteresis unless keep-floor is set.
// - On turn-on the fan spins at full until two tachometer_input rising edges.
// - Acoustic bits 7,6,5 keep outputs 3,2,1 at floor below threshold.
// - Outputs sharing a channel share its threshold but use own floors.
// - Each output has an 8-bit floor duty register, 0.39 percent steps.
// - Automatic duty never exceeds the output ceiling except on overtemp and during spin-up full duty.
// - Overtemperature forces all outputs to full duty, ignoring ceilings.
// - Ceiling registers reset to 0xFF, which imposes no limit.
// - Each output has an 8-bit ceiling register coded like the floor.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "afc_consts.vh"
module afc_fan_mux #(
  parameter integer NOUT = 3
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         err_o,
  input  wire [7:0]  temp_remote_a_i,
  input  wire [7:0]  temp_local_i,
  input  wire [7:0]  temp_remote_b_i,
  input  wire        overtemp_signal_i,
  input  wire [2:0]  tachometer_input_i,
  output reg  [7:0]  fan_drive_output_1_o,
  output reg  [7:0]  fan_drive_output_2_o,
  output reg  [7:0]  fan_drive_output_3_o
);

  // Register file
  reg [7:0] man_duty [0:2];
  reg [7:0] ceil     [0:2];
  reg [7:0] floor_r  [0:2];
  reg [7:0] cfg      [0:2];
  reg [7:0] tstart   [0:2];
  reg [7:0] acou;
  reg [7:0] fan_off_hysteresis;

  // Synchronisers for pin inputs
  reg       ot_s1;
  reg       ot_s2;
  reg [2:0] tachometer_input_s1;
  reg [2:0] tachometer_input_s2;
  reg [2:0] tachometer_input_d;

  // Per-channel on state and per-output spin-up state
  reg [2:0] chan_on;
  reg [2:0] spin;
  reg [1:0] edges [0:2];
  reg [2:0] was_on;

  wire [7:0] temps [0:2];
  assign temps[0] = temp_remote_a_i;
  assign temps[1] = temp_local_i;
  assign temps[2] = temp_remote_b_i;

  wire req = cyc_i & stb_i & ~ack_o & ~err_o;
  wire wr  = req & we_i & sel_i[0];
  wire offset64 = acou[`AFC_FMT_BIT];

  // Map a reading to an unsigned ordering key
  function [8:0] tkey;
    input [7:0] t;
    input       off64;
    begin
      if (off64)
        tkey = {1'b0, t};
      else
        tkey = {1'b0, t[7] ^ 1'b1, t[6:0]};
    end
  endfunction

  function [7:0] max8;
    input [7:0] a;
    input [7:0] b;
    begin
      max8 = (a > b) ? a : b;
    end
  endfunction

  // True when a configuration byte selects software duty
  function is_manual;
    input [7:0] cfg_byte;
    begin
      is_manual = (cfg_byte[`AFC_BHV_HI:`AFC_BHV_LO] == `AFC_BHV_MANUAL);
    end
  endfunction

  // Address decode
  reg        hit;
  reg [31:0] rdata;
  always @* begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    if (adr_i == `AFC_OFF_MAN1)
      rdata[7:0] = man_duty[0];
    else if (adr_i == `AFC_OFF_MAN2)
      rdata[7:0] = man_duty[1];
    else if (adr_i == `AFC_OFF_MAN3)
      rdata[7:0] = man_duty[2];
    else if (adr_i == `AFC_OFF_CEIL1)
      rdata[7:0] = ceil[0];
    else if (adr_i == `AFC_OFF_CEIL2)
      rdata[7:0] = ceil[1];
    else if (adr_i == `AFC_OFF_CEIL3)
      rdata[7:0] = ceil[2];
    else if (adr_i == `AFC_OFF_CFG1)
      rdata[7:0] = cfg[0];
    else if (adr_i == `AFC_OFF_CFG2)
      rdata[7:0] = cfg[1];
    else if (adr_i == `AFC_OFF_CFG3)
      rdata[7:0] = cfg[2];
    else if (adr_i == `AFC_OFF_ACOU)
      rdata[7:0] = acou;
    else if (adr_i == `AFC_OFF_FLOOR1)
      rdata[7:0] = floor_r[0];
    else if (adr_i == `AFC_OFF_FLOOR2)
      rdata[7:0] = floor_r[1];
    else if (adr_i == `AFC_OFF_FLOOR3)
      rdata[7:0] = floor_r[2];
    else if (adr_i == `AFC_OFF_TSTA)
      rdata[7:0] = tstart[0];
    else if (adr_i == `AFC_OFF_TSTL)
      rdata[7:0] = tstart[1];
    else if (adr_i == `AFC_OFF_TSTB)
      rdata[7:0] = tstart[2];
    else if (adr_i == `AFC_OFF_HYST)
      rdata[7:0] = fan_off_hysteresis;
    else if (adr_i == `AFC_OFF_STATUS)
      rdata[7:0] = {1'b0, spin, 1'b0, chan_on};
    else
      hit = 1'b0;
  end

  // Bus answer one cycle after request; unmapped gives err
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req & hit;
      err_o <= req & ~hit;
      dat_o <= (req & hit & ~we_i) ? rdata : 32'h0000_0000;
    end
  end

  // Register writes
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 3; i = i + 1) begin
        man_duty[i] <= `AFC_RST_MAN;
        ceil[i]     <= `AFC_RST_CEIL;
        floor_r[i]  <= `AFC_RST_FLOOR;
        cfg[i]      <= `AFC_RST_CFG;
        tstart[i]   <= `AFC_RST_TSTART;
      end
      acou               <= `AFC_RST_ACOU;
      fan_off_hysteresis <= `AFC_RST_HYST;
    end else if (wr) begin
      if (adr_i == `AFC_OFF_MAN1 && is_manual(cfg[0]))
        man_duty[0] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_MAN2 && is_manual(cfg[1]))
        man_duty[1] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_MAN3 && is_manual(cfg[2]))
        man_duty[2] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_CEIL1)
        ceil[0] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_CEIL2)
        ceil[1] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_CEIL3)
        ceil[2] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_CFG1)
        cfg[0] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_CFG2)
        cfg[1] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_CFG3)
        cfg[2] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_ACOU)
        acou <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_FLOOR1)
        floor_r[0] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_FLOOR2)
        floor_r[1] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_FLOOR3)
        floor_r[2] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_TSTA)
        tstart[0] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_TSTL)
        tstart[1] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_TSTB)
        tstart[2] <= dat_i[7:0];
      else if (adr_i == `AFC_OFF_HYST)
        fan_off_hysteresis <= dat_i[7:0];
    end
  end

  // Pin synchronisers
  always @(posedge clk_i) begin
    if (rst_i) begin
      ot_s1   <= 1'b0;
      ot_s2   <= 1'b0;
      tachometer_input_s1 <= 3'h0;
      tachometer_input_s2 <= 3'h0;
      tachometer_input_d  <= 3'h0;
    end else begin
      ot_s1   <= overtemp_signal_i;
      ot_s2   <= ot_s1;
      tachometer_input_s1 <= tachometer_input_i;
      tachometer_input_s2 <= tachometer_input_s1;
      tachometer_input_d  <= tachometer_input_s2;
    end
  end

  // Channel on/off with hysteresis, shared by all outputs on the channel
  reg [8:0] k_t;
  reg [8:0] k_on;
  reg [9:0] k_off;
  reg [2:0] next_chan_on;
  integer c;
  always @* begin
    next_chan_on = chan_on;
    k_t   = 9'h000;
    k_on  = 9'h000;
    k_off = 10'h000;
    for (c = 0; c < 3; c = c + 1) begin
      k_t   = tkey(temps[c], offset64);
      k_on  = tkey(tstart[c], offset64);
      k_off = {1'b0, k_on} - {2'b00, fan_off_hysteresis};
      if (k_t > k_on)
        next_chan_on[c] = 1'b1;
      else if (k_off[9] || {1'b0, k_t} < k_off)
        next_chan_on[c] = k_off[9] ? chan_on[c] : 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i)
      chan_on <= 3'h0;
    else
      chan_on <= next_chan_on;
  end

  // Per-output source selection and duty
  reg [7:0] duty  [0:2];
  reg [2:0] run;
  reg [2:0] want;
  reg [7:0] d;
  reg [2:0] b;
  reg [7:0] ch_a;
  reg [7:0] ch_l;
  reg [7:0] ch_b;
  reg [7:0] auto_d;
  integer o;
  always @* begin
    d = 8'h00;
    b = 3'h0;
    ch_a   = 8'h00;
    ch_l   = 8'h00;
    ch_b   = 8'h00;
    auto_d = 8'h00;
    for (o = 0; o < 3; o = o + 1) begin
      b       = cfg[o][`AFC_BHV_HI:`AFC_BHV_LO];
      want[o] = 1'b0;
      duty[o] = 8'h00;
      run[o]  = 1'b0;
      case (b)
        `AFC_BHV_REM_A:   run[o] = chan_on[0];
        `AFC_BHV_LOCAL:   run[o] = chan_on[1];
        `AFC_BHV_REM_B:   run[o] = chan_on[2];
        `AFC_BHV_LB_MAX:  run[o] = |chan_on[2:1];
        `AFC_BHV_ALL_MAX: run[o] = |chan_on;
        default:          run[o] = 1'b0;
      endcase
      // Floor then ceiling: the ceiling wins when set below the floor
      d = floor_r[o];
      if (d > ceil[o])
        d = ceil[o];
      // Per-channel duty, then the largest of the selected channels
      ch_a = chan_on[0] ? d : 8'h00;
      ch_l = chan_on[1] ? d : 8'h00;
      ch_b = chan_on[2] ? d : 8'h00;
      case (b)
        `AFC_BHV_REM_A:   auto_d = ch_a;
        `AFC_BHV_LOCAL:   auto_d = ch_l;
        `AFC_BHV_REM_B:   auto_d = ch_b;
        `AFC_BHV_LB_MAX:  auto_d = max8(ch_l, ch_b);
        `AFC_BHV_ALL_MAX: auto_d = max8(ch_a, max8(ch_l, ch_b));
        default:          auto_d = 8'h00;
      endcase
      case (b)
        `AFC_BHV_FULL:   duty[o] = `AFC_DUTY_FULL;
        `AFC_BHV_OFF:    duty[o] = 8'h00;
        `AFC_BHV_MANUAL: duty[o] = man_duty[o];
        `AFC_BHV_REM_A,
        `AFC_BHV_LOCAL,
        `AFC_BHV_REM_B,
        `AFC_BHV_LB_MAX,
        `AFC_BHV_ALL_MAX: begin
          want[o] = run[o];
          // Full from the turn-on cycle, before spin is registered
          if (run[o] && (spin[o] || !was_on[o]))
            duty[o] = `AFC_DUTY_FULL;
          else if (run[o])
            duty[o] = auto_d;
          else if (acou[`AFC_KEEP1_BIT + o])
            duty[o] = d;
          else
            duty[o] = 8'h00;
        end
        default:         duty[o] = 8'h00;
      endcase
      if (ot_s2)
        duty[o] = `AFC_DUTY_FULL;
    end
  end

  // Spin-up: full duty until two tachometer_input rising edges after turn-on
  integer s;
  always @(posedge clk_i) begin
    if (rst_i) begin
      spin   <= 3'h0;
      was_on <= 3'h0;
      for (s = 0; s < 3; s = s + 1)
        edges[s] <= 2'h0;
    end else begin
      was_on <= want;
      for (s = 0; s < 3; s = s + 1) begin
        if (want[s] && !was_on[s]) begin
          spin[s]  <= 1'b1;
          edges[s] <= 2'h0;
        end else if (!want[s]) begin
          spin[s]  <= 1'b0;
        end else if (spin[s] && tachometer_input_s2[s] && !tachometer_input_d[s]) begin
          if (edges[s] + 2'h1 >= `AFC_TACHOMETER_INPUT_EDGES)
            spin[s] <= 1'b0;
          edges[s] <= edges[s] + 2'h1;
        end
      end
    end
  end

  // Registered duty outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      fan_drive_output_1_o <= 8'h00;
      fan_drive_output_2_o <= 8'h00;
      fan_drive_output_3_o <= 8'h00;
    end else begin
      fan_drive_output_1_o <= duty[0];
      fan_drive_output_2_o <= duty[1];
      fan_drive_output_3_o <= duty[2];
    end
  end

endmodule
`default_nettype wire

// ===== tb/afc_fan_model.sv
// Fan model: tachometer_input pulses while its drive is nonzero
`timescale 1ns/1ps
`default_nettype none
module afc_fan_model #(
  parameter integer HALF = 8
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] duty1_i,
  input  wire logic [7:0] duty2_i,
  input  wire logic [7:0] duty3_i,
  output var  logic [2:0] tachometer_input_o
);
  logic [23:0] d;
  logic [3:0]  cnt [3];
  assign d = {duty3_i, duty2_i, duty1_i};
  always @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (rst_i || d[i*8+:8] == 8'h00) begin
        cnt[i]    <= 4'h0;
        tachometer_input_o[i] <= 1'b0;
      end else if (cnt[i] == HALF - 1) begin
        cnt[i]    <= 4'h0;
        tachometer_input_o[i] <= ~tachometer_input_o[i];
      end else begin
        cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/afc_fan_mux_bench.sv
// Self-checking bench for the fan drive mux
`timescale 1ns/1ps
`default_nettype none
`include "afc_consts.vh"
module afc_fan_mux_bench;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc = 0, stb = 0, we = 0, ovt = 0, e;
  logic [3:0]  sel = 0, bsel = 4'h1;
  logic [7:0]  adr = 0, ta = 0, tl = 0, tb = 0, q;
  logic [7:0]  fl1, fl2, cl1, x1, x2;
  logic [31:0] wdat = 0, rnd = 32'h231b_5706;
  logic [2:0]  tachometer_input;
  wire  [31:0] rdat;
  wire         ack, err;
  wire  [7:0]  f1, f2, f3;
  int          error_cnt = 0, total_checks = 0;
  logic [15:0] rv [13] = '{16'h38ff, 16'h39ff, 16'h3aff, 16'h6480,
    16'h6580, 16'h6680, 16'h679a, 16'h689a, 16'h699a, 16'h5c80, 16'h3000,
    16'h6a04, 16'h6200};
  logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  initial forever #2.5 clk_i = ~clk_i;
  afc_fan_mux DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .err_o(err), .temp_remote_a_i(ta), .temp_local_i(tl),
    .temp_remote_b_i(tb), .overtemp_signal_i(ovt),
    .tachometer_input_i(tachometer_input), .fan_drive_output_1_o(f1),
    .fan_drive_output_2_o(f2), .fan_drive_output_3_o(f3));
  afc_fan_model u_fan (
    .clk_i(clk_i), .rst_i(rst_i), .duty1_i(f1), .duty2_i(f2),
    .duty3_i(f3), .tachometer_input_o(tachometer_input));
  function automatic [31:0] lfsr(input [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic [7:0] clampd(input [7:0] fl, input [7:0] cl);
    return (fl > cl) ? cl : fl;
  endfunction
  function automatic bit src_on(input [2:0] c, input int k);
    case (c)
      3'h0: return k == 0;
      3'h1: return k == 1;
      3'h2: return k == 2;
      3'h5: return k != 0;
      default: return 1'b1;
    endcase
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task bus(input w, input [7:0] a, input [7:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1;
    stb  <= 1;
    we   <= w;
    sel  <= bsel;
    adr  <= a;
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ack && !err && n < 20);
    q = rdat[7:0];
    e = err;
    cyc <= 0;
    stb <= 0;
    we  <= 0;
    sel <= 4'h0;
    check(n < 20, 1);
  endtask
  task temps(input [7:0] a, input [7:0] l, input [7:0] b);
    @(posedge clk_i);
    ta <= a;
    tl <= l;
    tb <= b;
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    check({f1, f2, f3}, 0);
    foreach (rv[i]) begin
      bus(0, rv[i][15:8], 8'h00);
      check(q, rv[i][7:0]);
    end
    bus(0, 8'h70, 8'h00);
    check(e, 1);
    bsel = 4'h0;
    bus(1, `AFC_OFF_CEIL3, 8'h12);
    bsel = 4'h1;
    bus(0, `AFC_OFF_CEIL3, 8'h00);
    check(q, 8'hff);
    $display("test reset_values done");
    bus(1, `AFC_OFF_TSTA, 8'h28);
    bus(1, `AFC_OFF_TSTL, 8'h28);
    bus(1, `AFC_OFF_TSTB, 8'h28);
    bus(1, `AFC_OFF_CFG1, 8'h60);
    temps(8'h10, 8'h10, 8'h10);
    check(f1, 8'hff);
    rnd = lfsr(rnd);
    bus(1, `AFC_OFF_MAN2, rnd[7:0] | 8'h01);
    bus(0, `AFC_OFF_MAN2, 8'h00);
    check(q, 0);
    bus(1, `AFC_OFF_CFG2, 8'he0);
    bus(1, `AFC_OFF_MAN2, rnd[7:0]);
    bus(0, `AFC_OFF_MAN2, 8'h00);
    check(q, rnd[7:0]);
    repeat (3) @(posedge clk_i);
    check(f2, rnd[7:0]);
    check(f3, 0);
    $display("test full_manual done");
    foreach (codes[c]) begin
      for (int k = 0; k < 3; k++) begin
        rnd = lfsr(rnd);
        fl1 = {1'b0, rnd[6:0]};
        fl2 = {1'b0, rnd[14:8]};
        cl1 = rnd[23:16];
        bus(1, `AFC_OFF_FLOOR1, fl1);
        bus(1, `AFC_OFF_FLOOR2, fl2);
        bus(1, `AFC_OFF_CEIL1, cl1);
        bus(1, `AFC_OFF_CFG1, {codes[c], 5'h00});
        bus(1, `AFC_OFF_CFG2, {codes[c], 5'h00});
        temps(8'h10, 8'h10, 8'h10);
        check({f1, f2}, 0);
        temps(k == 0 ? 8'h50 : 8'h10, k == 1 ? 8'h50 : 8'h10,
              k == 2 ? 8'h50 : 8'h10);
        x1 = src_on(codes[c], k) ? clampd(fl1, cl1) : 8'h00;
        x2 = src_on(codes[c], k) ? fl2 : 8'h00;
        check({f1, f2}, {16{src_on(codes[c], k)}});
        repeat (80) @(posedge clk_i);
        check(f1, x1);
        check(f2, x2);
      end
    end
    $display("test mux_codes done");
    bus(1, `AFC_OFF_ACOU, 8'h20);
    temps(8'h10, 8'h10, 8'h26);
    check({f1, f2}, {x1, x2});
    temps(8'h10, 8'h10, 8'h10);
    check({f1, f2}, {x1, 8'h00});
    $display("test keep_floor done");
    bus(1, `AFC_OFF_ACOU, 8'h21);
    temps(8'h10, 8'h10, 8'h90);
    check({f1, f2}, 16'hffff);
    $display("test offset64 done");
    @(posedge clk_i);
    ovt <= 1;
    repeat (4) @(posedge clk_i);
    check({f1, f2, f3}, 24'hff_ffff);
    ovt <= 0;
    $display("test overtemp done");
    final_report;
  end
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
endmodule
`default_nettype wire

// ===== tb/afc_fan_mux_checker.sv
// Port assertions for the fan drive mux
`timescale 1ns/1ps
`default_nettype none
module afc_fan_mux_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire [7:0]  adr_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire        err_o,
  input wire        overtemp_signal_i,
  input wire [7:0]  fan_drive_output_1_o,
  input wire [7:0]  fan_drive_output_2_o,
  input wire [7:0]  fan_drive_output_3_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take   = cyc_i && stb_i && !ack_o && !err_o;
  wire mapped = adr_i inside {[8'h30:8'h32], [8'h38:8'h3a],
                              [8'h5c:8'h5e], 8'h62, [8'h64:8'h6b]};
  wire [7:0] f1 = fan_drive_output_1_o;
  wire [7:0] f2 = fan_drive_output_2_o;
  wire [7:0] f3 = fan_drive_output_3_o;
  property p_ovt;
    overtemp_signal_i [*4] |-> f1 == 8'hff && f2 == 8'hff && f3 == 8'hff;
  endproperty
  property p_rst;
    $past(rst_i) |-> f1 == 8'h00 && f2 == 8'h00 && f3 == 8'h00 && !ack_o;
  endproperty
  property p_ackp; ack_o |=> !ack_o; endproperty
  property p_errp; err_o |=> !err_o; endproperty
  property p_resp;
    take |=> ack_o == $past(mapped) && err_o == !$past(mapped);
  endproperty
  property p_stray; !(cyc_i && stb_i) |=> !ack_o && !err_o; endproperty
  property p_idle; !ack_o |-> dat_o == 32'h0000_0000; endproperty
  property p_datr; ack_o |-> dat_o[31:8] == 24'h00_0000; endproperty
  a_ovt: assert property (p_ovt)
    else $error("overtemp did not force full duty");
  a_rst: assert property (p_rst)
    else $error("outputs not quiet after reset");
  a_ackp: assert property (p_ackp)
    else $error("ack longer than one cycle");
  a_errp: assert property (p_errp)
    else $error("err longer than one cycle");
  a_resp: assert property (p_resp)
    else $error("wrong answer to a bus request");
  a_stray: assert property (p_stray)
    else $error("answer without request");
  a_idle: assert property (p_idle)
    else $error("read data not zero when idle");
  a_datr: assert property (p_datr)
    else $error("upper read data not zero");
  c_ovt: cover property (overtemp_signal_i [*4]);
  c_err: cover property (err_o);
  c_ack: cover property (ack_o && f1 != 8'h00);
endmodule
bind afc_fan_mux afc_fan_mux_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .overtemp_signal_i(overtemp_signal_i),
  .fan_drive_output_1_o(fan_drive_output_1_o),
  .fan_drive_output_2_o(fan_drive_output_2_o),
  .fan_drive_output_3_o(fan_drive_output_3_o));
`default_nettype wire
